/* File: hw/scss_top.sv */
// system clock source select: locked oscillator control, fail detect, stop recovery
//
// Operation
// - after unlock pair, next write loads and relocks
// - any other write sequence leaves register unchanged
// - unlock values ordered, gaps allowed, progress kept
// - other register accesses never disturb unlock state
// - three-bit field picks system clock source
// - fail detect bit enables watchdog oscillator monitor
// - stop recovery waits 66 or 5000 oscillator cycles
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps

module scss_top #(
    parameter logic [7:0] UNLOCK_FIRST_VAL = scss_pkg::UNLOCK_FIRST,
    parameter int         WDT_FAIL_CYC     = scss_pkg::WDT_FAIL_CYCLES,
    parameter int         SMR_SHORT_CYC    = scss_pkg::SMR_IPO_CYC_XTAL_OFF,
    parameter int         SMR_LONG_CYC     = scss_pkg::SMR_IPO_CYC_XTAL_ON
) (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // register port
    input  wire scss_pkg::scss_bus_req_t bus_req,
    output logic [scss_pkg::DATA_W-1:0] rd_data_q,
    // oscillator side
    input  wire logic                   ipo_tick,
    input  wire logic                   wdt_osc_tick,
    input  wire logic                   stop_recover_req,
    // clock control outputs
    output logic [2:0]                  clk_sel_q,
    output logic                        ipo_en_q,
    output logic                        xtal_en_q,
    output logic                        wdt_fail_en_q,
    output logic                        wdt_osc_fail_q,
    output logic                        recovery_busy_q,
    output logic                        resume_q,
    // interrupt
    output logic                        irq_q
);
    import scss_pkg::*;

    localparam int WDT_CNT_W = $clog2(WDT_FAIL_CYC + 1);
    localparam int SMR_CNT_W = $clog2(SMR_LONG_CYC + 1);
    localparam logic [WDT_CNT_W-1:0] WDT_LIMIT = WDT_CNT_W'(WDT_FAIL_CYC);
    localparam logic [SMR_CNT_W-1:0] SMR_SHORT = SMR_CNT_W'(SMR_SHORT_CYC);
    localparam logic [SMR_CNT_W-1:0] SMR_LONG  = SMR_CNT_W'(SMR_LONG_CYC);

    ////////////////////////////////////////////////////////////////////////////
    // reset release
    logic rst_meta_q;
    logic rst_q_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_q_n    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_q_n    <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decode
    scss_lock_t     lock_q;
    scss_osc_ctrl_t osc_q;
    logic [IRQ_W-1:0] status_q;
    logic [IRQ_W-1:0] mask_q;
    logic [IRQ_W-1:0] evt;
    logic [IRQ_W-1:0] w1c;
    logic             osc_wr;
    logic             osc_load;
    logic             wr_ignored;
    logic             fail_evt;
    logic [WDT_CNT_W-1:0] wdt_cnt_q;
    logic [SMR_CNT_W-1:0] smr_cnt_q;

    assign osc_wr   = bus_req.wr && (bus_req.addr == OFF_OSC_CTRL);
    assign osc_load = osc_wr && (lock_q == LOCK_OPEN);

    always_comb begin
        wr_ignored = 1'b0;
        if (osc_wr) begin
            unique case (lock_q)
                LOCK_IDLE:  wr_ignored = (bus_req.wdata != UNLOCK_FIRST_VAL);
                LOCK_FIRST: wr_ignored = (bus_req.wdata != UNLOCK_SECOND);
                LOCK_OPEN:  wr_ignored = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // unlock sequencer; only oscillator control writes move it
    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            lock_q <= LOCK_IDLE;
        end else if (osc_wr) begin
            unique case (lock_q)
                LOCK_IDLE: begin
                    if (bus_req.wdata == UNLOCK_FIRST_VAL) begin
                        lock_q <= LOCK_FIRST;
                    end
                end
                LOCK_FIRST: begin
                    // a wrong second value drops back; the pair must restart
                    lock_q <= (bus_req.wdata == UNLOCK_SECOND) ? LOCK_OPEN : LOCK_IDLE;
                end
                LOCK_OPEN: begin
                    lock_q <= LOCK_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // oscillator control register
    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            osc_q <= scss_osc_ctrl_t'(OSC_CTRL_RESET);
        end else if (osc_load) begin
            osc_q <= scss_osc_ctrl_t'(bus_req.wdata & OSC_CTRL_MASK);
        end
    end

    assign ipo_en_q      = osc_q.ipo_en;
    assign xtal_en_q     = osc_q.xtal_en;
    assign wdt_fail_en_q = osc_q.wdt_osc_fail_detect_en;

    // reserved codes keep the running source; switching to nothing would stop the chip
    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            clk_sel_q <= SRC_IPO_FAST;
        end else if (osc_load && (bus_req.wdata[OSC_SEL_LSB +: 3] <= SRC_EXT_PIN)) begin
            clk_sel_q <= bus_req.wdata[OSC_SEL_LSB +: 3];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // watchdog oscillator failure monitor
    assign fail_evt = wdt_fail_en_q && !wdt_osc_fail_q && !wdt_osc_tick
                      && (wdt_cnt_q == WDT_LIMIT - 1'b1);

    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            wdt_cnt_q      <= '0;
            wdt_osc_fail_q <= 1'b0;
        end else if (!wdt_fail_en_q || wdt_osc_tick) begin
            wdt_cnt_q      <= '0;
            wdt_osc_fail_q <= 1'b0;
        end else if (fail_evt) begin
            wdt_cnt_q      <= WDT_LIMIT;
            wdt_osc_fail_q <= 1'b1;
        end else if (!wdt_osc_fail_q) begin
            wdt_cnt_q <= wdt_cnt_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // stop mode recovery delay, counted in internal oscillator ticks
    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            smr_cnt_q       <= '0;
            recovery_busy_q <= 1'b0;
            resume_q        <= 1'b0;
        end else begin
            resume_q <= 1'b0;
            if (!recovery_busy_q) begin
                if (stop_recover_req) begin
                    recovery_busy_q <= 1'b1;
                    smr_cnt_q       <= xtal_en_q ? SMR_LONG : SMR_SHORT;
                end
            end else if (ipo_tick) begin
                if (smr_cnt_q == SMR_CNT_W'(1)) begin
                    recovery_busy_q <= 1'b0;
                    resume_q        <= 1'b1;
                end
                smr_cnt_q <= smr_cnt_q - 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status, mask and output; a set wins over a same-cycle clear
    always_comb begin
        evt                = '0;
        evt[ST_WDT_FAIL]   = fail_evt;
        evt[ST_RECOVERED]  = recovery_busy_q && ipo_tick && (smr_cnt_q == SMR_CNT_W'(1));
        evt[ST_IGNORED_WR] = wr_ignored;
        w1c = (bus_req.wr && (bus_req.addr == OFF_IRQ_STATUS)) ? bus_req.wdata[IRQ_W-1:0] : '0;
    end

    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~w1c) | evt;
        end
    end

    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            mask_q <= '0;
        end else if (bus_req.wr && (bus_req.addr == OFF_IRQ_MASK)) begin
            mask_q <= bus_req.wdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            rd_data_q <= '0;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                OFF_OSC_CTRL:   rd_data_q <= osc_q;
                OFF_IRQ_STATUS: rd_data_q <= {{(DATA_W-IRQ_W){1'b0}}, status_q};
                OFF_IRQ_MASK:   rd_data_q <= {{(DATA_W-IRQ_W){1'b0}}, mask_q};
                OFF_CLK_STATE:  rd_data_q <= {2'b00, clk_sel_q, recovery_busy_q, lock_q};
                default:        rd_data_q <= '0;
            endcase
        end else begin
            rd_data_q <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    logic [SMR_CNT_W-1:0] smr_seen_q;
    logic [SMR_CNT_W-1:0] smr_tgt_q;

    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            smr_seen_q <= '0;
            smr_tgt_q  <= '0;
        end else if (!recovery_busy_q && stop_recover_req) begin
            smr_seen_q <= '0;
            smr_tgt_q  <= xtal_en_q ? SMR_LONG : SMR_SHORT;
        end else if (recovery_busy_q && ipo_tick) begin
            smr_seen_q <= smr_seen_q + 1'b1;
        end
    end

    property p_open_loads;
        @(posedge clk) disable iff (!rst_q_n)
        osc_load |=> (osc_q == $past(bus_req.wdata & OSC_CTRL_MASK)) && (lock_q == LOCK_IDLE);
    endproperty
    a_open_loads: assert property (p_open_loads) else $error("open write not loaded");

    property p_locked_keeps;
        @(posedge clk) disable iff (!rst_q_n)
        (bus_req.wr && !osc_load) |=> $stable(osc_q);
    endproperty
    a_locked_keeps: assert property (p_locked_keeps) else $error("locked reg changed");

    property p_pair_order;
        @(posedge clk) disable iff (!rst_q_n)
        (osc_wr && lock_q == LOCK_FIRST && bus_req.wdata == UNLOCK_SECOND) ##1
        (!osc_wr)[*2] |-> lock_q == LOCK_OPEN;
    endproperty
    a_pair_order: assert property (p_pair_order) else $error("unlock progress lost");

    property p_other_access;
        @(posedge clk) disable iff (!rst_q_n)
        !osc_wr |=> $stable(lock_q);
    endproperty
    a_other_access: assert property (p_other_access) else $error("lock state disturbed");

    property p_sel_follows;
        @(posedge clk) disable iff (!rst_q_n)
        (osc_load && bus_req.wdata[2:0] <= SRC_EXT_PIN) |=> clk_sel_q == $past(bus_req.wdata[2:0]);
    endproperty
    a_sel_follows: assert property (p_sel_follows) else $error("source not selected");

    property p_sel_legal;
        @(posedge clk) disable iff (!rst_q_n)
        clk_sel_q <= SRC_EXT_PIN;
    endproperty
    a_sel_legal: assert property (p_sel_legal) else $error("reserved source active");

    property p_fail_off;
        @(posedge clk) disable iff (!rst_q_n)
        (!wdt_fail_en_q || wdt_osc_tick) |=> !wdt_osc_fail_q;
    endproperty
    a_fail_off: assert property (p_fail_off) else $error("fail flag while off");

    property p_fail_rise;
        @(posedge clk) disable iff (!rst_q_n)
        $rose(wdt_osc_fail_q) |-> $past(wdt_cnt_q) == WDT_LIMIT - 1'b1 && status_q[ST_WDT_FAIL];
    endproperty
    a_fail_rise: assert property (p_fail_rise) else $error("fail timing wrong");

    property p_smr_count;
        @(posedge clk) disable iff (!rst_q_n)
        resume_q |-> (smr_seen_q == smr_tgt_q) && !recovery_busy_q;
    endproperty
    a_smr_count: assert property (p_smr_count) else $error("recovery count wrong");

    property p_reset_locked;
        @(posedge clk)
        !rst_q_n |-> lock_q == LOCK_IDLE;
    endproperty
    a_reset_locked: assert property (p_reset_locked) else $error("not locked in reset");

    property p_irq;
        @(posedge clk) disable iff (!rst_q_n)
        |(status_q & mask_q) |=> irq_q;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not raised");

endmodule : scss_top

/* File: shared/scss_pkg.sv */
// package for the system clock source select block: map, fields, codes, timing
package scss_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register bus
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    localparam logic [ADDR_W-1:0] OFF_OSC_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h01;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK   = 8'h02;
    localparam logic [ADDR_W-1:0] OFF_CLK_STATE  = 8'h03;

    ////////////////////////////////////////////////////////////////////////////
    // oscillator control unlock values and layout
    localparam logic [DATA_W-1:0] UNLOCK_FIRST   = 8'h07;
    localparam logic [DATA_W-1:0] UNLOCK_SECOND  = 8'h18;
    localparam logic [DATA_W-1:0] OSC_CTRL_RESET = 8'h80;
    localparam logic [DATA_W-1:0] OSC_CTRL_MASK  = 8'hE7;

    localparam int OSC_SEL_LSB    = 0;
    localparam int OSC_WDFAIL_BIT = 5;
    localparam int OSC_XTAL_BIT   = 6;
    localparam int OSC_IPO_BIT    = 7;

    // clock source codes
    localparam logic [2:0] SRC_IPO_FAST = 3'h0;
    localparam logic [2:0] SRC_IPO_SLOW = 3'h1;
    localparam logic [2:0] SRC_XTAL     = 3'h2;
    localparam logic [2:0] SRC_WDT_OSC  = 3'h3;
    localparam logic [2:0] SRC_EXT_PIN  = 3'h4;

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status bits
    localparam int IRQ_W         = 3;
    localparam int ST_WDT_FAIL   = 0;
    localparam int ST_RECOVERED  = 1;
    localparam int ST_IGNORED_WR = 2;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_MHZ              = 25;
    localparam int WDT_FAIL_TIME_US     = 400;
    localparam int WDT_FAIL_CYCLES      = WDT_FAIL_TIME_US * CLK_MHZ;
    localparam int SMR_IPO_CYC_XTAL_OFF = 66;
    localparam int SMR_IPO_CYC_XTAL_ON  = 5000;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        LOCK_IDLE,
        LOCK_FIRST,
        LOCK_OPEN
    } scss_lock_t;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } scss_bus_req_t;

    typedef struct packed {
        logic       ipo_en;
        logic       xtal_en;
        logic       wdt_osc_fail_detect_en;
        logic [1:0] rsvd;
        logic [2:0] clock_source_select;
    } scss_osc_ctrl_t;

endpackage : scss_pkg

/* File: verif/scss_osc_model.sv */
// oscillator source model: precision and watchdog oscillator tick pulses
`timescale 1ns/1ps

module scss_osc_model #(
    parameter int IPO_DIV = 4,
    parameter int WDT_DIV = 8
) (
    // clock
    input  wire logic clk,
    // watchdog oscillator run control
    input  wire logic wdt_run,
    // oscillator ticks
    output logic      ipo_tick,
    output logic      wdt_osc_tick
);
    int ipo_cnt_q = 0;
    int wdt_cnt_q = 0;

    ////////////////////////////////////////////////////////////////////////////
    // sparse ticks so one tick is never confused with its neighbour
    always_ff @(posedge clk) begin
        ipo_cnt_q <= (ipo_cnt_q >= IPO_DIV - 1) ? 0 : ipo_cnt_q + 1;
        ipo_tick  <= (ipo_cnt_q == IPO_DIV - 1);
    end

    ////////////////////////////////////////////////////////////////////////////
    // a stopped watchdog oscillator gives no ticks at all
    always_ff @(posedge clk) begin
        wdt_cnt_q    <= (!wdt_run || wdt_cnt_q >= WDT_DIV - 1) ? 0 : wdt_cnt_q + 1;
        wdt_osc_tick <= wdt_run && (wdt_cnt_q == WDT_DIV - 1);
    end

endmodule : scss_osc_model

/* File: verif/tb_top.sv */
// testbench for the system clock source select block
`timescale 1ns/1ps

module tb_top;
    import scss_pkg::*;

    localparam int WDT_FAIL  = 20;
    localparam int SMR_SHORT = 5;
    localparam int SMR_LONG  = 50;

    logic          clk              = 1'b0;
    logic          rst_n            = 1'b0;
    scss_bus_req_t bus_req          = '0;
    logic          stop_recover_req = 1'b0;
    logic          wdt_run          = 1'b1;
    logic [7:0]    rd_data_q;
    logic          ipo_tick;
    logic          wdt_osc_tick;
    logic [2:0]    clk_sel_q;
    logic          ipo_en_q;
    logic          xtal_en_q;
    logic          wdt_fail_en_q;
    logic          wdt_osc_fail_q;
    logic          recovery_busy_q;
    logic          resume_q;
    logic          irq_q;
    logic [7:0]    rv;
    logic [2:0]    sel_exp;
    int            mismatches = 0;
    int            checks     = 0;
    int            cycles     = 0;

    scss_top #(.WDT_FAIL_CYC(WDT_FAIL), .SMR_SHORT_CYC(SMR_SHORT), .SMR_LONG_CYC(SMR_LONG))
    u_scss_top (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rd_data_q(rd_data_q),
        .ipo_tick(ipo_tick), .wdt_osc_tick(wdt_osc_tick), .stop_recover_req(stop_recover_req),
        .clk_sel_q(clk_sel_q), .ipo_en_q(ipo_en_q), .xtal_en_q(xtal_en_q),
        .wdt_fail_en_q(wdt_fail_en_q), .wdt_osc_fail_q(wdt_osc_fail_q),
        .recovery_busy_q(recovery_busy_q), .resume_q(resume_q), .irq_q(irq_q));

    scss_osc_model u_scss_osc_model (.clk(clk), .wdt_run(wdt_run), .ipo_tick(ipo_tick),
        .wdt_osc_tick(wdt_osc_tick));

    always #20 clk = ~clk;

    // hang guard, far beyond the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus_req <= '0;
    endtask : wr

    task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        bus_req <= '0;
        #1;
        check(name, rd_data_q, exp);
    endtask : rchk

    task automatic osc_write(input logic [7:0] v);
        wr(OFF_OSC_CTRL, UNLOCK_FIRST);
        wr(OFF_OSC_CTRL, UNLOCK_SECOND);
        wr(OFF_OSC_CTRL, v);
    endtask : osc_write

    // counts precision oscillator ticks seen while the recovery delay runs
    task automatic recover(input int exp_ticks);
        int t;
        t = 0;
        @(posedge clk);
        stop_recover_req <= 1'b1;
        @(posedge clk);
        stop_recover_req <= 1'b0;
        #1;
        // a tick standing now is the one the design takes at the next edge
        for (int i = 0; i < 2000 && resume_q !== 1'b1; i++) begin
            if (ipo_tick === 1'b1 && recovery_busy_q === 1'b1) t++;
            @(posedge clk);
            #1;
        end
        check("resume", {7'h0, resume_q}, 8'h01);
        check("busy end", {7'h0, recovery_busy_q}, 8'h00);
        check("ticks", 8'(t), 8'(exp_ticks));
    endtask : recover

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rchk("osc reset", OFF_OSC_CTRL, OSC_CTRL_RESET);
        check("sel reset", {5'h0, clk_sel_q}, 8'h00);
        // lone, reversed and broken sequences
        wr(OFF_OSC_CTRL, 8'h02);
        wr(OFF_OSC_CTRL, UNLOCK_SECOND);
        wr(OFF_OSC_CTRL, UNLOCK_FIRST);
        wr(OFF_OSC_CTRL, 8'h03);
        rchk("osc locked", OFF_OSC_CTRL, OSC_CTRL_RESET);
        rchk("lock idle", OFF_CLK_STATE, 8'h00);
        // gapped unlock with other register traffic in between
        wr(OFF_OSC_CTRL, UNLOCK_FIRST);
        rchk("lock first", OFF_CLK_STATE, 8'h01);
        wr(OFF_IRQ_MASK, 8'h00);
        repeat (3) @(posedge clk);
        wr(OFF_OSC_CTRL, UNLOCK_SECOND);
        rchk("lock open", OFF_CLK_STATE, 8'h02);
        wr(OFF_OSC_CTRL, 8'hF8);
        rchk("osc loaded", OFF_OSC_CTRL, 8'hE0);
        check("enables", {5'h0, ipo_en_q, xtal_en_q, wdt_fail_en_q}, 8'h07);
        wr(OFF_OSC_CTRL, 8'h81);
        rchk("osc relocked", OFF_OSC_CTRL, 8'hE0);
        // every source code, reserved ones keep the old source; the crystal is
        // already on, the watchdog oscillator runs and the pin is taken as set up
        sel_exp = SRC_IPO_FAST;
        for (int c = 0; c < 8; c++) begin
            osc_write(8'hC0 | 8'(c));
            if (c <= 4) sel_exp = 3'(c);
            rchk("osc code", OFF_OSC_CTRL, 8'hC0 | 8'(c));
            check("sel out", {5'h0, clk_sel_q}, {5'h0, sel_exp});
            rchk("state sel", OFF_CLK_STATE, {2'b00, sel_exp, 3'b000});
        end
        // interrupt from an ignored write: raise, mask, clear
        wr(OFF_IRQ_STATUS, 8'h07);
        rchk("status clear", OFF_IRQ_STATUS, 8'h00);
        wr(OFF_OSC_CTRL, 8'h01);
        rchk("status ignored", OFF_IRQ_STATUS, 8'h04);
        wr(OFF_IRQ_MASK, 8'h04);
        rchk("mask", OFF_IRQ_MASK, 8'h04);
        check("irq on", {7'h0, irq_q}, 8'h01);
        wr(OFF_IRQ_MASK, 8'h00);
        rchk("unmapped", 8'h40, 8'h00);
        check("irq masked", {7'h0, irq_q}, 8'h00);
        wr(OFF_IRQ_MASK, 8'h05);
        wr(OFF_IRQ_STATUS, 8'h04);
        rchk("status w1c", OFF_IRQ_STATUS, 8'h00);
        check("irq off", {7'h0, irq_q}, 8'h00);
        // watchdog oscillator stops: judged dead only while detection is on
        @(posedge clk);
        wdt_run <= 1'b0;
        repeat (WDT_FAIL + 10) @(posedge clk);
        #1;
        check("fail off", {7'h0, wdt_osc_fail_q}, 8'h00);
        osc_write(8'hA0);
        repeat (WDT_FAIL + 10) @(posedge clk);
        #1;
        check("fail on", {7'h0, wdt_osc_fail_q}, 8'h01);
        check("irq fail", {7'h0, irq_q}, 8'h01);
        rchk("status fail", OFF_IRQ_STATUS, 8'h01);
        @(posedge clk);
        wdt_run <= 1'b1;
        repeat (20) @(posedge clk);
        #1;
        check("fail gone", {7'h0, wdt_osc_fail_q}, 8'h00);
        // stop recovery, crystal off then on
        wr(OFF_IRQ_STATUS, 8'h07);
        recover(SMR_SHORT);
        rchk("status done", OFF_IRQ_STATUS, 8'h02);
        osc_write(8'hC0);
        recover(SMR_LONG);
        // reset in mid sequence drops the half-done unlock
        wr(OFF_OSC_CTRL, UNLOCK_FIRST);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        wr(OFF_OSC_CTRL, UNLOCK_SECOND);
        wr(OFF_OSC_CTRL, 8'h22);
        rchk("osc after reset", OFF_OSC_CTRL, OSC_CTRL_RESET);
        close_out();
    end

endmodule : tb_top
